/* File: hdl/line_codec_config_registers.sv */
// Configuration and status register bank of a four-channel voice codec.
// Assumes the framer hands over one command (with its data byte) per
// request, and one downstream SC C/I field per channel with a strobe.
//
// Functional notes
// RULE1: Command 70h/71h accesses operating conditions; bit 7 cuts transmit.
// RULE2: Command bit 0 low writes the data byte, high returns contents.
// RULE3: Receive cutoff bit cuts receive path and disables B filter.
// RULE4: Highpass-disable bit bypasses the transmit highpass filter.
// RULE5: Gain-reduce bit inserts 6 dB loss in receive path.
// RULE6: Transmit interrupt armed only while arm bit is one.
// RULE7: Separate bits enable interface loopback and full digital loopback.
// RULE8: Bit 0 injects a 1 kHz receive tone.
// RULE9: Command 46h/47h; global top bit picks push-pull or open-drain IRQ.
// RULE10: Global chopper bit picks 2048 kHz divided by 8 or by 7.
// RULE11: Controller writes reserved bits as zero, never trusts them on read.
// RULE12: Command 60h/61h; bit 6 picks A-law or mu-law.
// RULE13: Bits 5..0 pick default or programmed coefficients per filter.
// RULE14: Command 54h/55h; bit 6 is read-only channel active status.
// RULE15: Activate 0Eh sets active status; deactivate 00h clears it.
// RULE16: Bit 5 is global read-only clock-fail flag for every channel.
// RULE17: Bits 4..0 set each line pin direction, one means output.
// RULE18: Command 4Ah/4Bh; global bit floats idle output or holds reference.
// RULE19: Legacy low-power bit is stored but has no effect.
// RULE20: Command 53h returns live pin levels, two extra outputs, hook bit.
// RULE21: Muxed hook bit meaningful only while sample multiplexing enabled.
// RULE22: Input pins send detect bits and pin three level upstream.
// RULE23: Output pins follow downstream C/I bits, not sent upstream.
// RULE24: Command 52h loads output states until next downstream C/I arrives.
// RULE25: Per-channel fields stored per channel; global fields stored once.
module line_codec_config_registers
   import line_codec_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   // Monitor channel
   input  wire monitor_req_t         monitor_req,
   output monitor_rsp_t              monitor_rsp,
   // Line pins, per channel
   input  wire logic [4:0]           line_pin_in [NUM_CHANNELS],
   output logic [4:0]                line_pin_out [NUM_CHANNELS],
   output logic [4:0]                line_pin_oe [NUM_CHANNELS],
   output logic [1:0]                extra_out [NUM_CHANNELS],
   // SC channel C/I fields, per channel
   input  wire logic [NUM_CHANNELS-1:0] ci_down_valid,
   input  wire logic [6:0]           ci_down [NUM_CHANNELS],
   output logic [2:0]                ci_up [NUM_CHANNELS],
   output logic [2:0]                ci_up_valid [NUM_CHANNELS],
   // Detect inputs from the debounce block
   input  wire logic [NUM_CHANNELS-1:0] debounced_detect_a,
   input  wire logic [NUM_CHANNELS-1:0] debounced_detect_b,
   input  wire logic [NUM_CHANNELS-1:0] muxed_hook_bit,
   input  wire logic                 sample_mux_enable,
   input  wire logic                 frame_sync_lost_flag,
   // Controls toward the voice path
   output channel_ctrl_t             channel_ctrl [NUM_CHANNELS],
   output logic [NUM_CHANNELS-1:0]   channel_active_flag,
   output logic                      irq_output_type,
   output logic [2:0]                chopper_divide,
   output logic                      legacy_power_bit
);

   // Command matches independent of the direction bit
   function automatic logic cmd_is(input logic [7:0] cmd,
                                   input logic [7:0] base);
      cmd_is = (cmd[7:1] == base[7:1]);
   endfunction

   logic [7:0] operating_conditions [NUM_CHANNELS];
   logic [6:0] operating_functions  [NUM_CHANNELS];
   logic [4:0] pin_direction_bits   [NUM_CHANNELS];
   logic [6:0] pin_out_state        [NUM_CHANNELS];
   logic       channel_active       [NUM_CHANNELS];
   logic [1:0] chip_configuration;
   logic [1:0] operating_mode;

   wire        req_v     = monitor_req.valid;
   wire  [1:0] req_ch    = monitor_req.channel;
   wire  [7:0] req_cmd   = monitor_req.command;
   wire  [7:0] req_data  = monitor_req.data;
   // RULE2: direction bit
   wire        req_read  = req_cmd[0];
   wire        req_write = req_v & ~req_read;
   wire        hard_rst  = reset | (req_v & (req_cmd == CMD_HARD_RESET));
   wire        soft_rst  = req_v & (req_cmd == CMD_SOFT_RESET);

   // RULE9: chip configuration write
   wire wr_chip = req_write & cmd_is(req_cmd, CMD_CHIP_CONFIGURATION);
   // RULE18: operating mode write
   wire wr_mode = req_write & cmd_is(req_cmd, CMD_OPERATING_MODE);

   // RULE25: global fields stored once
   always_ff @(posedge core_clk) begin
      if (hard_rst) begin
         chip_configuration <= CHIP_CONFIGURATION_RST;
         operating_mode     <= OPERATING_MODE_RST;
      end else begin
         if (wr_chip) begin
            chip_configuration <= req_data[CC_IRQ_TYPE:CC_CHOPPER];
         end
         if (wr_mode) begin
            operating_mode <= req_data[OM_IDLE_OUTPUT:OM_LEGACY_POWER];
         end
      end
   end

   // RULE25: per-channel storage selected by channel address
   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g++) begin : chan
         wire sel    = (req_ch == 2'(g));
         wire my_rst = hard_rst | (soft_rst & sel);
         wire wr     = req_write & sel;
         // RULE1: operating conditions write
         wire wr_oc  = wr & cmd_is(req_cmd, CMD_OPERATING_CONDITIONS);
         // RULE12: operating functions write
         wire wr_of  = wr & cmd_is(req_cmd, CMD_OPERATING_FUNCTIONS);
         // RULE14: status bits are not writable
         wire wr_pd  = wr & cmd_is(req_cmd, CMD_PIN_DIRECTION);
         // RULE24: direct pin write, outputs only
         wire wr_ps  = wr & (req_cmd == CMD_PIN_STATE_WRITE);
         wire act    = req_v & sel & (req_cmd == CMD_ACTIVATE);
         wire deact  = req_v & sel & (req_cmd == CMD_DEACTIVATE);
         wire [7:0] oc = operating_conditions[g];
         wire [4:0] dir = pin_direction_bits[g];
         wire [6:0] out_mask = {2'h3, dir};
         wire idle_float = ~channel_active[g] & operating_mode[1];

         always_ff @(posedge core_clk) begin
            if (my_rst) begin
               operating_conditions[g] <= OPERATING_CONDITIONS_RST;
               operating_functions[g]  <= OPERATING_FUNCTIONS_RST;
               pin_direction_bits[g]   <= PIN_DIRECTION_RST;
               pin_out_state[g]        <= PIN_OUT_RST;
               channel_active[g]       <= 1'b0;
            end else begin
               if (wr_oc) begin
                  operating_conditions[g] <= req_data;
               end
               if (wr_of) begin
                  operating_functions[g] <= req_data[6:0];
               end
               if (wr_pd) begin
                  pin_direction_bits[g] <= req_data[4:0];
               end
               // RULE24: downstream C/I overrides direct write
               if (ci_down_valid[g]) begin
                  pin_out_state[g] <= ci_down[g];
               end else if (wr_ps) begin
                  pin_out_state[g] <= req_data[6:0] & out_mask;
               end
               // RULE15: activate / deactivate
               if (act) begin
                  channel_active[g] <= 1'b1;
               end else if (deact) begin
                  channel_active[g] <= 1'b0;
               end
            end
         end

         always_ff @(posedge core_clk) begin
            if (reset) begin
               channel_ctrl[g]        <= '0;
               line_pin_out[g]        <= '0;
               line_pin_oe[g]         <= '0;
               extra_out[g]           <= '0;
               ci_up[g]               <= '0;
               ci_up_valid[g]         <= '0;
               channel_active_flag[g] <= 1'b0;
            end else begin
               // RULE1: transmit cutoff
               channel_ctrl[g].tx_path_cutoff     <= oc[OC_TX_CUTOFF];
               // RULE3: receive cutoff also disables B filter
               channel_ctrl[g].rx_path_cutoff     <= oc[OC_RX_CUTOFF];
               channel_ctrl[g].balance_filter_off <= oc[OC_RX_CUTOFF];
               // RULE4: highpass bypass
               channel_ctrl[g].tx_highpass_disable <= oc[OC_HP_DISABLE];
               // RULE5: 6 dB receive loss
               channel_ctrl[g].rx_gain_reduce     <= oc[OC_RX_GAIN_RED];
               // RULE6: transmit interrupt arm
               channel_ctrl[g].tx_irq_arm         <= oc[OC_TX_IRQ_ARM];
               // RULE7: loopbacks
               channel_ctrl[g].interface_loopback <= oc[OC_IF_LOOPBACK];
               channel_ctrl[g].full_digital_loopback <= oc[OC_FULL_LOOP];
               // RULE8: test tone
               channel_ctrl[g].rx_test_tone       <= oc[OC_TEST_TONE];
               // RULE12: companding law
               channel_ctrl[g].mu_law <= operating_functions[g][OF_MU_LAW];
               // RULE13: coefficient selection
               channel_ctrl[g].filter_custom <= operating_functions[g][5:0];
               // RULE18: idle analog output behaviour
               channel_ctrl[g].analog_output_float <= idle_float;
               channel_ctrl[g].analog_output_ref   <=
                  ~channel_active[g] & ~operating_mode[1];
               channel_active_flag[g] <= channel_active[g];
               // RULE17: pin direction; RULE23: outputs follow C/I
               line_pin_oe[g]  <= dir;
               line_pin_out[g] <= pin_out_state[g][4:0];
               extra_out[g]    <= pin_out_state[g][6:5];
               // RULE22: inputs go upstream; RULE23: outputs do not
               ci_up[g] <= {line_pin_in[g][2],
                            sample_mux_enable ? muxed_hook_bit[g]
                                              : debounced_detect_b[g],
                            debounced_detect_a[g]};
               ci_up_valid[g] <= ~{dir[2], dir[1], dir[0]};
            end
         end
      end
   endgenerate

   // Read data selection for the addressed channel
   wire [7:0] rd_oc = operating_conditions[req_ch];
   wire [7:0] rd_cc = {chip_configuration, 6'h00};
   wire [7:0] rd_of = {1'b0, operating_functions[req_ch]};
   // RULE14: active status; RULE16: global clock-fail flag
   wire [7:0] rd_pd = {1'b0, channel_active[req_ch], frame_sync_lost_flag,
                       pin_direction_bits[req_ch]};
   wire [7:0] rd_om = {2'h0, operating_mode, 4'h0};
   // RULE20: live levels; RULE21: hook bit valid only when multiplexed
   wire [7:0] rd_ps = {pin_out_state[req_ch][6:5], muxed_hook_bit[req_ch],
                       line_pin_in[req_ch]};

   wire       rd_hit_oc = cmd_is(req_cmd, CMD_OPERATING_CONDITIONS);
   wire       rd_hit_cc = cmd_is(req_cmd, CMD_CHIP_CONFIGURATION);
   wire       rd_hit_of = cmd_is(req_cmd, CMD_OPERATING_FUNCTIONS);
   wire       rd_hit_pd = cmd_is(req_cmd, CMD_PIN_DIRECTION);
   wire       rd_hit_om = cmd_is(req_cmd, CMD_OPERATING_MODE);
   wire       rd_hit_ps = (req_cmd == CMD_PIN_STATE_READ);
   // RULE2: read answers only on read commands
   wire       rd_any = req_v & req_read &
                       (rd_hit_oc | rd_hit_cc | rd_hit_of |
                        rd_hit_pd | rd_hit_om | rd_hit_ps);
   wire [7:0] rd_data = rd_hit_oc ? rd_oc :
                        rd_hit_cc ? rd_cc :
                        rd_hit_of ? rd_of :
                        rd_hit_pd ? rd_pd :
                        rd_hit_om ? rd_om :
                        rd_hit_ps ? rd_ps : 8'h00;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         monitor_rsp      <= '0;
         irq_output_type  <= 1'b0;
         chopper_divide   <= CHOP_DIV_EIGHT;
         legacy_power_bit <= 1'b0;
      end else begin
         monitor_rsp.valid <= rd_any;
         monitor_rsp.data  <= rd_any ? rd_data : 8'h00;
         // RULE9: interrupt output type
         irq_output_type   <= chip_configuration[1];
         // RULE10: chopper divide by 8 or 7
         chopper_divide    <= chip_configuration[0] ? CHOP_DIV_SEVEN
                                                    : CHOP_DIV_EIGHT;
         // RULE19: stored only, drives nothing functional
         legacy_power_bit  <= operating_mode[0];
      end
   end

endmodule

/* File: hdl/line_codec_cfg_pkg.sv */
// Constants and carriers for the codec configuration register bank.
// Assumes a framer that delivers decoded monitor bytes and SC C/I fields.
package line_codec_cfg_pkg;

   localparam int          NUM_CHANNELS = 4;
   localparam int          NUM_PINS     = 5;

   // Command bytes, write form except CMD_PIN_STATE_READ (read form has bit 0 set)
   localparam logic [7:0]  CMD_OPERATING_CONDITIONS = 8'h70;
   localparam logic [7:0]  CMD_CHIP_CONFIGURATION   = 8'h46;
   localparam logic [7:0]  CMD_OPERATING_FUNCTIONS  = 8'h60;
   localparam logic [7:0]  CMD_PIN_DIRECTION        = 8'h54;
   localparam logic [7:0]  CMD_OPERATING_MODE       = 8'h4A;
   localparam logic [7:0]  CMD_PIN_STATE_WRITE      = 8'h52;
   localparam logic [7:0]  CMD_PIN_STATE_READ       = 8'h53;
   localparam logic [7:0]  CMD_ACTIVATE             = 8'h0E;
   localparam logic [7:0]  CMD_DEACTIVATE           = 8'h00;
   localparam logic [7:0]  CMD_SOFT_RESET           = 8'h02;
   localparam logic [7:0]  CMD_HARD_RESET           = 8'h04;

   // Reset values
   localparam logic [7:0]  OPERATING_CONDITIONS_RST = 8'h00;
   localparam logic [1:0]  CHIP_CONFIGURATION_RST   = 2'h0;
   localparam logic [6:0]  OPERATING_FUNCTIONS_RST  = 7'h00;
   localparam logic [4:0]  PIN_DIRECTION_RST        = 5'h00;
   localparam logic [1:0]  OPERATING_MODE_RST       = 2'h0;
   localparam logic [6:0]  PIN_OUT_RST              = 7'h00;

   // Field positions
   localparam int          OC_TX_CUTOFF    = 7;
   localparam int          OC_RX_CUTOFF    = 6;
   localparam int          OC_HP_DISABLE   = 5;
   localparam int          OC_RX_GAIN_RED  = 4;
   localparam int          OC_TX_IRQ_ARM   = 3;
   localparam int          OC_IF_LOOPBACK  = 2;
   localparam int          OC_FULL_LOOP    = 1;
   localparam int          OC_TEST_TONE    = 0;
   localparam int          CC_IRQ_TYPE     = 7;
   localparam int          CC_CHOPPER      = 6;
   localparam int          OF_MU_LAW       = 6;
   localparam int          PD_ACTIVE       = 6;
   localparam int          PD_SYNC_LOST    = 5;
   localparam int          OM_IDLE_OUTPUT  = 5;
   localparam int          OM_LEGACY_POWER = 4;

   // Chopper divide ratios from the 2048 kHz clock
   localparam logic [2:0]  CHOP_DIV_EIGHT  = 3'h7;
   localparam logic [2:0]  CHOP_DIV_SEVEN  = 3'h6;

   // One decoded monitor-channel transfer
   typedef struct packed {
      logic        valid;
      logic [1:0]  channel;
      logic [7:0]  command;
      logic [7:0]  data;
   } monitor_req_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  data;
   } monitor_rsp_t;

   // Per-channel analog path controls
   typedef struct packed {
      logic        tx_path_cutoff;
      logic        rx_path_cutoff;
      logic        balance_filter_off;
      logic        tx_highpass_disable;
      logic        rx_gain_reduce;
      logic        tx_irq_arm;
      logic        interface_loopback;
      logic        full_digital_loopback;
      logic        rx_test_tone;
      logic        mu_law;
      logic [5:0]  filter_custom;
      logic        analog_output_float;
      logic        analog_output_ref;
   } channel_ctrl_t;

endpackage

/* File: test/line_codec_cfg_properties.sv */
// Port assertions for the codec configuration register bank.
// Bound onto the bank from tb_top; sees its ports only.
module line_codec_cfg_checker
   import line_codec_cfg_pkg::*;
(
   // Clock and reset
   input wire logic          core_clk,
   input wire logic          reset,
   // Monitor channel
   input wire monitor_req_t  monitor_req,
   input wire monitor_rsp_t  monitor_rsp,
   // Pins and C/I
   input wire logic [4:0]    line_pin_in [NUM_CHANNELS],
   input wire logic [4:0]    line_pin_out [NUM_CHANNELS],
   input wire logic [4:0]    line_pin_oe [NUM_CHANNELS],
   input wire logic [NUM_CHANNELS-1:0] ci_down_valid,
   input wire logic [6:0]    ci_down [NUM_CHANNELS],
   input wire logic [2:0]    ci_up_valid [NUM_CHANNELS],
   // Controls
   input wire channel_ctrl_t channel_ctrl [NUM_CHANNELS],
   input wire logic [NUM_CHANNELS-1:0] channel_active_flag,
   input wire logic          irq_output_type,
   input wire logic [2:0]    chopper_divide
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   read_answer_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h71 |=> monitor_rsp.valid)
      else $error("read got no answer");
   write_silent_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h70 |=> !monitor_rsp.valid)
      else $error("write answered");
   cond_write_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h70
      && monitor_req.channel == 2'h0 |-> ##2
      channel_ctrl[0].tx_path_cutoff == $past(monitor_req.data[7], 2)
      && channel_ctrl[0].rx_test_tone == $past(monitor_req.data[0], 2))
      else $error("operating conditions not applied");
   b_filter_off_a: assert property (
      channel_ctrl[0].rx_path_cutoff |-> channel_ctrl[0].balance_filter_off)
      else $error("balance filter on during cutoff");
   chip_config_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h46 |-> ##2
      chopper_divide == ($past(monitor_req.data[6], 2) ? CHOP_DIV_SEVEN
                                                       : CHOP_DIV_EIGHT)
      && irq_output_type == $past(monitor_req.data[7], 2))
      else $error("chip configuration not applied");
   activate_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h0E
      && monitor_req.channel == 2'h0 |-> ##[1:2] channel_active_flag[0])
      else $error("channel not activated");
   deactivate_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h00
      && monitor_req.channel == 2'h0 |-> ##[1:2] !channel_active_flag[0])
      else $error("channel not deactivated");
   ci_drives_a: assert property (
      ci_down_valid[0] && line_pin_oe[0] == 5'h1F |-> ##2
      line_pin_out[0] == $past(ci_down[0][4:0], 2))
      else $error("output pins not following C/I");
   up_valid_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h54
      && monitor_req.channel == 2'h0 |-> ##3
      ci_up_valid[0] == ~$past(monitor_req.data[2:0], 3))
      else $error("upstream valid not per direction");
   pin_read_a: assert property (
      monitor_req.valid && monitor_req.command == 8'h53
      && monitor_req.channel == 2'h0 |=>
      monitor_rsp.data[4:0] == $past(line_pin_in[0]))
      else $error("pin read wrong");
endmodule

/* File: test/gci_controller_model.sv */
// Upstream controller model: monitor commands and downstream C/I fields.
// Assumes one bench process calls its tasks, starting off a falling edge.
module gci_controller_model
   import line_codec_cfg_pkg::*;
(
   // Clock
   input  wire logic             core_clk,
   // Monitor channel
   output monitor_req_t          monitor_req,
   input  wire monitor_rsp_t     monitor_rsp,
   // Downstream C/I
   output logic [NUM_CHANNELS-1:0] ci_down_valid,
   output logic [6:0]            ci_down [NUM_CHANNELS]
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      monitor_req = '0;
      ci_down_valid = '0;
      ci_down = '{default: 7'h00};
   end

   // direction bit, caller zeroes reserved bits
   task automatic send(input logic [1:0] ch, input logic [7:0] cmd,
                       input logic [7:0] dat);
      @(posedge core_clk);
      monitor_req <= '{1'b1, ch, cmd, dat};
      @(posedge core_clk);
      // Released lines must not keep the old value
      monitor_req <= '{1'b0, ~ch, ~cmd, ~dat};
   endtask

   task automatic write(input logic [1:0] ch, input logic [7:0] cmd,
                        input logic [7:0] dat);
      send(ch, cmd, dat);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic read(input logic [1:0] ch, input logic [7:0] cmd,
                       output logic [7:0] dat);
      dat = 8'hXX;
      send(ch, cmd, 8'h00);
      for (int n = 0; n < 4; n++) begin
         @(negedge core_clk);
         if (monitor_rsp.valid === 1'b1) begin
            dat = monitor_rsp.data;
         end
      end
   endtask

   task automatic push_ci(input logic [1:0] ch, input logic [6:0] v);
      @(posedge core_clk);
      ci_down[ch] <= v;
      ci_down_valid[ch] <= 1'b1;
      @(posedge core_clk);
      ci_down_valid[ch] <= 1'b0;
      ci_down[ch] <= ~v;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the codec configuration register bank.
// Commands go through the controller model; line pins are resolved here.
module tb_top
   import line_codec_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   monitor_req_t monitor_req;
   monitor_rsp_t monitor_rsp;
   logic [4:0] line_pin_in [4], line_pin_out [4], line_pin_oe [4];
   logic [4:0] ext_pins [4] = '{default: 5'h00};
   logic [1:0] extra_out [4];
   logic [3:0] ci_down_valid, channel_active_flag;
   logic [6:0] ci_down [4];
   logic [2:0] ci_up [4], ci_up_valid [4];
   logic [3:0] det_a = 4'h0, det_b = 4'h0, hook = 4'h0;
   logic mux_en = 1'b0, sync_lost = 1'b0, irq_type, legacy;
   logic [2:0] chop;
   channel_ctrl_t channel_ctrl [4];
   int num_errors = 0;
   int checks_done = 0;
   always #25 core_clk = ~core_clk;
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         line_pin_in[c] = (line_pin_oe[c] & line_pin_out[c])
                        | (~line_pin_oe[c] & ext_pins[c]);
      end
   end
   line_codec_config_registers line_codec_config_registers_i (
      .core_clk(core_clk), .reset(reset), .monitor_req(monitor_req),
      .monitor_rsp(monitor_rsp), .line_pin_in(line_pin_in),
      .line_pin_out(line_pin_out), .line_pin_oe(line_pin_oe),
      .extra_out(extra_out), .ci_down_valid(ci_down_valid),
      .ci_down(ci_down), .ci_up(ci_up), .ci_up_valid(ci_up_valid),
      .debounced_detect_a(det_a), .debounced_detect_b(det_b),
      .muxed_hook_bit(hook), .sample_mux_enable(mux_en),
      .frame_sync_lost_flag(sync_lost), .channel_ctrl(channel_ctrl),
      .channel_active_flag(channel_active_flag),
      .irq_output_type(irq_type), .chopper_divide(chop),
      .legacy_power_bit(legacy));
   gci_controller_model gci_controller_model_i (
      .core_clk(core_clk), .monitor_req(monitor_req),
      .monitor_rsp(monitor_rsp), .ci_down_valid(ci_down_valid),
      .ci_down(ci_down));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [1:0] ch, input logic [7:0] cmd,
                        input logic [7:0] exp);
      logic [7:0] v;
      gci_controller_model_i.read(ch, cmd, v);
      chk(v, exp);
   endtask
   task automatic wr(input logic [1:0] ch, input logic [7:0] cmd,
                     input logic [7:0] d);
      gci_controller_model_i.write(ch, cmd, d);
   endtask
   function automatic logic [7:0] oc_bits(input channel_ctrl_t c);
      return {c.tx_path_cutoff, c.rx_path_cutoff, c.tx_highpass_disable,
              c.rx_gain_reduce, c.tx_irq_arm, c.interface_loopback,
              c.full_digital_loopback, c.rx_test_tone};
   endfunction
   task automatic results();
      $display("errors %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      static logic [7:0] rd_cmd [5] = '{8'h71, 8'h47, 8'h61, 8'h55, 8'h4B};
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      @(negedge core_clk);
      for (int r = 0; r < 5; r++) rdchk(2'h1, rd_cmd[r], 8'h00);
      chk({5'h00, chop}, {5'h00, CHOP_DIV_EIGHT});
      for (int b = 0; b < 9; b++) begin
         wr(2'h0, 8'h70, 8'h01 << b);
         chk(oc_bits(channel_ctrl[0]), 8'h01 << b);
         chk({6'h00, channel_ctrl[0].rx_path_cutoff,
              channel_ctrl[0].balance_filter_off},
             {6'h00, b == 6, b == 6});
         rdchk(2'h0, 8'h71, 8'h01 << b);
      end
      wr(2'h0, 8'h70, 8'hFF);
      chk(oc_bits(channel_ctrl[3]), 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(2'h1, 8'h46, 8'h40 << i);
         rdchk(2'h2, 8'h47, 8'h40 << i);
         chk({irq_type, 4'h0, chop},
             {i == 1, 4'h0, i ? CHOP_DIV_EIGHT : CHOP_DIV_SEVEN});
      end
      for (int i = 0; i < 2; i++) begin
         wr(2'h2, 8'h60, i ? 8'h2A : 8'h55);
         chk({1'b0, channel_ctrl[2].mu_law, channel_ctrl[2].filter_custom},
             i ? 8'h2A : 8'h55);
         rdchk(2'h2, 8'h61, i ? 8'h2A : 8'h55);
      end
      wr(2'h3, 8'h4A, 8'h30);
      rdchk(2'h0, 8'h4B, 8'h30);
      chk({legacy, channel_ctrl[3].analog_output_float,
           channel_ctrl[3].analog_output_ref}, 8'h06);
      wr(2'h0, 8'h54, 8'h1F);
      rdchk(2'h0, 8'h55, 8'h1F);
      chk({3'h0, line_pin_oe[0]}, 8'h1F);
      wr(2'h0, 8'h0E, 8'h00);
      rdchk(2'h0, 8'h55, 8'h5F);
      sync_lost <= 1'b1;
      rdchk(2'h3, 8'h55, 8'h20);
      sync_lost <= 1'b0;
      wr(2'h0, 8'h00, 8'h00);
      rdchk(2'h0, 8'h55, 8'h1F);
      gci_controller_model_i.push_ci(2'h0, 7'h5A);
      chk({extra_out[0], 1'b0, line_pin_out[0]}, 8'h9A);
      rdchk(2'h0, 8'h53, 8'h9A | {2'h0, hook[0], 5'h00});
      wr(2'h0, 8'h52, 8'h45);
      chk({extra_out[0], 1'b0, line_pin_out[0]}, 8'h85);
      gci_controller_model_i.push_ci(2'h0, 7'h00);
      chk({ci_up_valid[0], line_pin_out[0]}, 8'h00);
      wr(2'h0, 8'h54, 8'h00);
      ext_pins[0] <= 5'h15;
      det_a <= 4'h1;
      hook <= 4'h1;
      rdchk(2'h0, 8'h53, 8'h35);
      chk({ci_up_valid[0], 2'h0, ci_up[0]}, 8'hE5);
      mux_en <= 1'b1;
      rdchk(2'h0, 8'h53, 8'h35);
      chk({5'h00, ci_up[0]}, 8'h07);
      wr(2'h1, 8'h46, 8'h40);
      wr(2'h2, 8'h04, 8'h00);
      rdchk(2'h0, 8'h71, 8'h00);
      chk({5'h00, chop}, {5'h00, CHOP_DIV_EIGHT});
      results();
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      results();
   end
endmodule

bind line_codec_config_registers line_codec_cfg_checker
   line_codec_cfg_checker_i (
   .core_clk(core_clk), .reset(reset), .monitor_req(monitor_req),
   .monitor_rsp(monitor_rsp), .line_pin_in(line_pin_in),
   .line_pin_out(line_pin_out), .line_pin_oe(line_pin_oe),
   .ci_down_valid(ci_down_valid), .ci_down(ci_down),
   .ci_up_valid(ci_up_valid), .channel_ctrl(channel_ctrl),
   .channel_active_flag(channel_active_flag),
   .irq_output_type(irq_output_type), .chopper_divide(chopper_divide));
